/* File: rtl/pst_regs.vh */
/*
 * register offsets, field positions, reset values and write masks of the
 * prescaler and timer block. assumes byte-wide registers on a plain port.
 */
// Overview of operation
// RQ1 - fast prescaler is a 16-bit counter feeding base timer and timer 1
// RQ2 - reading the prescaler register returns fast prescaler low byte
// RQ3 - writing one to prescaler bit 7 clears the fast prescaler
// RQ4 - prescaler bit 6 runs the fast prescaler; zero stops the source
// RQ5 - prescaler bit 5 selects system clock (0) or external pin events (1)
// RQ6 - with external events, fast prescaler and timer 1 form 16-bit counter; code: timer 1 counts tap edges, every 2nd event in mode 7
// RQ7 - slow prescaler is 8-bit on crystal clock, stops only on reset
// RQ8 - base timer is 8-bit up counter, wrap sets its request flag
// RQ9 - base select 0-7 taps source/65536 down to /2, stops when disabled
// RQ10 - base select 8-11 taps crystal /256,/64,/16,/4 regardless of run bit
// RQ11 - timer 0 count is read/write anytime; wrap sets timer 0 request
// RQ12 - timer 0 stops whenever the system clock stops
// RQ13 - timer 0 mode 0-6 taps source/65536 down to /8
// RQ14 - timer 0 mode bit 4 enables automatic reload
// RQ15 - timer 0 mode bit 5 enables counting
// RQ16 - timer 1 halts in standby; base timer keeps counting
// RQ17 - timer 1 modes 0-7 source taps, 8-11 crystal /256,/128,/64,/32
// RQ18 - timer 1 mode bit 4 enables automatic reload
// RQ19 - timer 1 count register is live, readable and writable
// RQ20 - reload loads last software written value on overflow, else zero
// RQ21 - timer 1 wrap sets its flag; flags reach cpu only when enabled
`ifndef PST_REGS_VH
`define PST_REGS_VH
`define PST_ADDR_BASE_SEL 8'h21
`define PST_ADDR_PRESCALER 8'h23
`define PST_ADDR_T0_MODE 8'h24
`define PST_ADDR_T0_COUNT 8'h25
`define PST_ADDR_T1_MODE 8'h26
`define PST_ADDR_T1_COUNT 8'h27
`define PST_ADDR_REQ 8'h3C
`define PST_ADDR_ENA 8'h3F
`define PST_PRS_CLEAR 7
`define PST_PRS_RUN 6
`define PST_PRS_INSEL 5
`define PST_T0_RELOAD 4
`define PST_T0_ENABLE 5
`define PST_T1_RELOAD 4
`define PST_REQ_T0 2
`define PST_REQ_T1 3
`define PST_REQ_BT 5
`define PST_REQ_MASK 8'h3F
`define PST_T0_MODE_MASK 8'h37
`define PST_T1_MODE_MASK 8'h1F
`define PST_RESET_BYTE 8'h00
`define PST_RESET_NIB 4'h0
`endif

/* File: rtl/pst_tap_select.v */
/*
 * tap multiplexer: turns a 4-bit select code into one of the prescaler
 * taps. assumes tap inputs already synchronous to clk.
 */
`timescale 1ns/10ps
module pst_tap_select (
    input wire [3:0] sel,
    input wire [15:0] fast_q,
    input wire [7:0] slow_q,
    input wire [1:0] table_kind,
    output reg tap
);
// ==========================================================
// tap selection
// table_kind 0: base timer, 1: timer 0, 2: timer 1
always @* begin
    tap = 1'b0;
    if (!sel[3]) begin
        case (sel[2:0])
            3'h0: tap = fast_q[15];
            3'h1: tap = fast_q[14];
            3'h2: tap = fast_q[12];
            3'h3: tap = fast_q[10];
            3'h4: tap = fast_q[7];
            3'h5: tap = fast_q[4];
            3'h6: tap = fast_q[2];
            default: tap = (table_kind == 2'h1) ? 1'b0 : fast_q[0];
        endcase
    end else if (table_kind == 2'h0) begin
        case (sel[1:0])
            2'h0: tap = slow_q[7];
            2'h1: tap = slow_q[5];
            2'h2: tap = slow_q[3];
            default: tap = slow_q[1];
        endcase
    end else if (table_kind == 2'h2) begin
        case (sel[1:0])
            2'h0: tap = slow_q[7];
            2'h1: tap = slow_q[6];
            2'h2: tap = slow_q[5];
            default: tap = slow_q[4];
        endcase
    end
end
endmodule

/* File: rtl/pst_timers.v */
/*
 * prescalers, base timer, timer 0 and timer 1 with request and enable
 * flags. assumes crystal clock and external pin are asynchronous inputs,
 * sampled here; the crystal must be much slower than clk.
 */
`timescale 1ns/10ps
`include "pst_regs.vh"
module pst_timers (
    input wire clk,
    input wire rst,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    input wire crystal_clock,
    input wire external_interrupt_pin,
    input wire system_clock_run,
    input wire processor_standby,
    output reg [7:0] rdata,
    output reg base_timer_irq,
    output reg timer0_irq,
    output reg timer1_irq
);
// ==========================================================
// input synchronisers
reg [1:0] xtal_sync;
reg [1:0] pin_sync;
reg xtal_last;
reg pin_last;
always @(posedge clk) begin
    if (rst) begin
        xtal_sync <= 2'h0;
        pin_sync <= 2'h0;
        xtal_last <= 1'b0;
        pin_last <= 1'b0;
    end else begin
        xtal_sync <= {xtal_sync[0], crystal_clock};
        pin_sync <= {pin_sync[0], external_interrupt_pin};
        xtal_last <= xtal_sync[1];
        pin_last <= pin_sync[1];
    end
end
wire xtal_tick = xtal_sync[1] & ~xtal_last;
wire pin_tick = pin_sync[1] & ~pin_last;
// ==========================================================
// registers
reg [3:0] base_sel;
reg prescaler_run;
reg prescaler_input_select;
reg [15:0] fast_prescaler;
reg [7:0] slow_prescaler;
reg [7:0] timer0_mode_reg;
reg [7:0] timer1_mode_reg;
reg [7:0] base_count;
reg [7:0] timer0_count_reg;
reg [7:0] timer1_count_reg;
reg [7:0] timer0_reload;
reg [7:0] timer1_reload;
reg [7:0] request_flags_reg;
reg [7:0] enable_flags_reg;
wire wr_prs = wr && addr == `PST_ADDR_PRESCALER;
wire wr_t0c = wr && addr == `PST_ADDR_T0_COUNT;
wire wr_t1c = wr && addr == `PST_ADDR_T1_COUNT;
wire wr_req = wr && addr == `PST_ADDR_REQ;
// ==========================================================
// prescalers
// RQ5 source select
wire fast_step = prescaler_input_select ? pin_tick : 1'b1;
wire [15:0] fast_inc = fast_prescaler + 16'h0001;
always @(posedge clk) begin
    if (rst) begin
        fast_prescaler <= 16'h0000;
        slow_prescaler <= `PST_RESET_BYTE;
        prescaler_run <= 1'b0;
        prescaler_input_select <= 1'b0;
    end else begin
        if (wr_prs) begin
            // RQ4 run control
            prescaler_run <= wdata[`PST_PRS_RUN];
            prescaler_input_select <= wdata[`PST_PRS_INSEL];
        end
        // RQ3 clear on write
        if (wr_prs && wdata[`PST_PRS_CLEAR])
            fast_prescaler <= 16'h0000;
        // RQ1 16-bit count
        else if (prescaler_run && fast_step)
            fast_prescaler <= fast_inc;
        // RQ7 free-running slow count
        if (xtal_tick)
            slow_prescaler <= slow_prescaler + 8'h01;
    end
end
// ==========================================================
// tap selection and edge detection
wire base_tap;
wire t0_tap;
wire t1_tap;
// RQ9 base timer source taps
pst_tap_select u_base_tap (
    .sel(base_sel),
    .fast_q(fast_prescaler),
    .slow_q(slow_prescaler),
    .table_kind(2'h0),
    .tap(base_tap)
);
// RQ13 timer 0 source taps
pst_tap_select u_t0_tap (
    .sel({1'b0, timer0_mode_reg[2:0]}),
    .fast_q(fast_prescaler),
    .slow_q(slow_prescaler),
    .table_kind(2'h1),
    .tap(t0_tap)
);
// RQ17 timer 1 source taps
pst_tap_select u_t1_tap (
    .sel(timer1_mode_reg[3:0]),
    .fast_q(fast_prescaler),
    .slow_q(slow_prescaler),
    .table_kind(2'h2),
    .tap(t1_tap)
);
reg base_tap_d;
reg t0_tap_d;
reg t1_tap_d;
// RQ10 crystal taps ignore the run bit, fast taps freeze when stopped
wire base_tick = base_tap & ~base_tap_d &
    (base_sel[3] ? base_sel[2] == 1'b0 : prescaler_run);
// RQ12 RQ15 timer 0 runs with system clock and its enable
wire t0_tick = t0_tap & ~t0_tap_d & prescaler_run &
    timer0_mode_reg[`PST_T0_ENABLE] & system_clock_run &
    timer0_mode_reg[2:0] != 3'h7;
// RQ16 timer 1 halts in standby
wire t1_tick = t1_tap & ~t1_tap_d & ~processor_standby &
    (timer1_mode_reg[3] ? timer1_mode_reg[2] == 1'b0 : prescaler_run);
always @(posedge clk) begin
    if (rst) begin
        base_tap_d <= 1'b0;
        t0_tap_d <= 1'b0;
        t1_tap_d <= 1'b0;
    end else begin
        base_tap_d <= base_tap;
        t0_tap_d <= t0_tap;
        t1_tap_d <= t1_tap;
    end
end
// ==========================================================
// counters
wire base_wrap = base_tick && base_count == 8'hFF;
wire t0_wrap = t0_tick && timer0_count_reg == 8'hFF;
wire t1_wrap = t1_tick && timer1_count_reg == 8'hFF;
always @(posedge clk) begin
    if (rst) begin
        base_sel <= `PST_RESET_NIB;
        base_count <= `PST_RESET_BYTE;
        timer0_mode_reg <= `PST_RESET_BYTE;
        timer1_mode_reg <= `PST_RESET_BYTE;
        timer0_count_reg <= `PST_RESET_BYTE;
        timer1_count_reg <= `PST_RESET_BYTE;
        timer0_reload <= `PST_RESET_BYTE;
        timer1_reload <= `PST_RESET_BYTE;
    end else begin
        if (wr && addr == `PST_ADDR_BASE_SEL)
            base_sel <= wdata[3:0];
        if (wr && addr == `PST_ADDR_T0_MODE)
            timer0_mode_reg <= wdata & `PST_T0_MODE_MASK;
        if (wr && addr == `PST_ADDR_T1_MODE)
            timer1_mode_reg <= wdata & `PST_T1_MODE_MASK;
        // RQ8 base timer up count
        if (base_tick)
            base_count <= base_count + 8'h01;
        // RQ11 software write wins over a count
        if (wr_t0c) begin
            timer0_count_reg <= wdata;
            timer0_reload <= wdata;
        // RQ14 RQ20 reload on overflow
        end else if (t0_wrap && timer0_mode_reg[`PST_T0_RELOAD])
            timer0_count_reg <= timer0_reload;
        else if (t0_tick)
            timer0_count_reg <= timer0_count_reg + 8'h01;
        // RQ19 live writable count
        if (wr_t1c) begin
            timer1_count_reg <= wdata;
            timer1_reload <= wdata;
        // RQ18 RQ20 reload on overflow
        end else if (t1_wrap && timer1_mode_reg[`PST_T1_RELOAD])
            timer1_count_reg <= timer1_reload;
        // RQ6 timer 1 counts rising edges of the selected pin-driven prescaler tap
        else if (t1_tick)
            timer1_count_reg <= timer1_count_reg + 8'h01;
    end
end
// ==========================================================
// request and enable flags
reg [7:0] next_req;
always @* begin
    next_req = request_flags_reg;
    if (wr_req)
        next_req = wdata & `PST_REQ_MASK;
    // RQ8 RQ11 RQ21 set beats clear
    if (base_wrap)
        next_req[`PST_REQ_BT] = 1'b1;
    if (t0_wrap)
        next_req[`PST_REQ_T0] = 1'b1;
    if (t1_wrap)
        next_req[`PST_REQ_T1] = 1'b1;
end
always @(posedge clk) begin
    if (rst) begin
        request_flags_reg <= `PST_RESET_BYTE;
        enable_flags_reg <= `PST_RESET_BYTE;
        base_timer_irq <= 1'b0;
        timer0_irq <= 1'b0;
        timer1_irq <= 1'b0;
    end else begin
        request_flags_reg <= next_req;
        if (wr && addr == `PST_ADDR_ENA)
            enable_flags_reg <= wdata & `PST_REQ_MASK;
        // RQ21 gated requests
        base_timer_irq <= request_flags_reg[`PST_REQ_BT] &
            enable_flags_reg[`PST_REQ_BT];
        timer0_irq <= request_flags_reg[`PST_REQ_T0] &
            enable_flags_reg[`PST_REQ_T0];
        timer1_irq <= request_flags_reg[`PST_REQ_T1] &
            enable_flags_reg[`PST_REQ_T1];
    end
end
// ==========================================================
// read port
always @(posedge clk) begin
    if (rst) begin
        rdata <= `PST_RESET_BYTE;
    end else if (rd) begin
        case (addr)
            // RQ2 low byte of fast prescaler
            `PST_ADDR_PRESCALER: rdata <= fast_prescaler[7:0];
            `PST_ADDR_T0_MODE: rdata <= timer0_mode_reg;
            `PST_ADDR_T0_COUNT: rdata <= timer0_count_reg;
            `PST_ADDR_T1_MODE: rdata <= timer1_mode_reg;
            `PST_ADDR_T1_COUNT: rdata <= timer1_count_reg;
            `PST_ADDR_REQ: rdata <= request_flags_reg;
            `PST_ADDR_ENA: rdata <= enable_flags_reg;
            default: rdata <= 8'h00;
        endcase
    end else begin
        rdata <= 8'h00;
    end
end
endmodule

/* File: bench/pst_timers_properties.sv */
/*
 * checker for the timer block: register port read data and irq outputs.
 * assumes it is bound to pst_timers and sees only its ports.
 */
`timescale 1ns/10ps
module pst_timers_properties (
    input wire clk,
    input wire rst,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    input wire [7:0] rdata,
    input wire base_timer_irq,
    input wire timer0_irq,
    input wire timer1_irq
);
default clocking cb @(posedge clk); endclocking
default disable iff (rst);
// ==========================================================
// register port
rdata_idle_a: assert property (
    !$past(rd) |-> rdata == 8'h00) else $error("read data not idle");
unmapped_zero_a: assert property (
    rd && (addr < 8'h21 || addr > 8'h3F) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
select_wo_a: assert property (
    rd && addr == 8'h21 |=> rdata == 8'h00)
    else $error("select register readable");
prs_clear_a: assert property (
    wr && addr == 8'h23 && wdata[7:6] == 2'b10 ##1 rd && addr == 8'h23
    |=> rdata == 8'h00) else $error("prescaler not cleared");
t0_mode_rb_a: assert property (
    wr && addr == 8'h24 ##1 rd && addr == 8'h24
    |=> rdata == ($past(wdata, 2) & 8'h37)) else $error("mode readback");
ena_rb_a: assert property (
    wr && addr == 8'h3F ##1 rd && addr == 8'h3F
    |=> rdata == ($past(wdata, 2) & 8'h3F)) else $error("enable readback");
// ==========================================================
// interrupt outputs
t0_mask_a: assert property (
    wr && addr == 8'h3F && !wdata[2] |=> ##1 !timer0_irq)
    else $error("timer0 irq not masked");
t1_mask_a: assert property (
    wr && addr == 8'h3F && !wdata[3] |=> ##1 !timer1_irq)
    else $error("timer1 irq not masked");
bt_mask_a: assert property (
    wr && addr == 8'h3F && !wdata[5] |=> ##1 !base_timer_irq)
    else $error("base irq not masked");
reset_quiet_a: assert property (
    $fell(rst) |-> !base_timer_irq && !timer0_irq && !timer1_irq)
    else $error("irq high after reset");
cover property ($rose(timer0_irq));
cover property ($rose(timer1_irq));
cover property ($rose(base_timer_irq));
endmodule
bind pst_timers pst_timers_properties chk (.clk(clk), .rst(rst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .base_timer_irq(base_timer_irq), .timer0_irq(timer0_irq),
    .timer1_irq(timer1_irq));

/* File: bench/pst_timers_tb.sv */
/*
 * self-checking bench for pst_timers: registers, timers and irqs.
 * assumes the checker file is compiled beside it.
 */
`timescale 1ns/10ps
module pst_timers_tb;
reg clk, rst, wr, rd, xtal, pin, sys_run, stby;
reg [7:0] addr, wdata;
wire [7:0] rdata;
wire bt_irq, t0_irq, t1_irq;
wire [2:0] irqs = {t1_irq, t0_irq, bt_irq};
int num_errors = 0;
int checks = 0;
logic [7:0] v1, v2;
int i;
pst_timers DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .crystal_clock(xtal),
    .external_interrupt_pin(pin), .system_clock_run(sys_run),
    .processor_standby(stby), .rdata(rdata), .base_timer_irq(bt_irq),
    .timer0_irq(t0_irq), .timer1_irq(t1_irq));
initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
end
// crystal slower than clk/4, unrelated phase
initial begin
    xtal = 1'b0;
    forever #163 xtal = ~xtal;
end
// ==========================================================
// bus and compare tasks
task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
        num_errors++;
        $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
endtask
task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    rd <= 1'b0;
    wr <= 1'b1;
endtask
task rd_val(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
endtask
task rd_chk(input logic [7:0] a, input logic [7:0] e, input string n);
    logic [7:0] v;
    rd_val(a, v);
    chk(n, e, v);
endtask
task idle(input int n);
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge clk);
endtask
task wait_irq(input int k, input int n);
    int c;
    c = 0;
    idle(0);
    while (irqs[k] !== 1'b1 && c < n) begin
        @(posedge clk);
        #1;
        c++;
    end
    chk("irq", 8'h01, {7'h00, irqs[k]});
endtask
task wrap_up;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
        $display("No errors found");
    else
        $display("Errors were found");
    $finish;
endtask
// ==========================================================
// scenarios
task t_reset;
    logic [7:0] m [9];
    m = '{8'h21, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h3C, 8'h3F, 8'h30};
    foreach (m[j]) rd_chk(m[j], 8'h00, "reset value");
endtask
task t_prs;
    wr_reg(8'h23, 8'hC0);
    rd_val(8'h23, v1);
    rd_val(8'h23, v2);
    chk("prs step", 8'h02, v2 - v1);
    wr_reg(8'h23, 8'h80);
    rd_chk(8'h23, 8'h00, "prs clear");
    rd_chk(8'h23, 8'h00, "prs stop");
endtask
task t_ext;
    wr_reg(8'h27, 8'h00);
    wr_reg(8'h26, 8'h07);
    wr_reg(8'h23, 8'hE0);
    idle(1);
    for (i = 0; i < 3; i++) begin
        @(posedge clk) pin <= 1'b1;
        repeat (4) @(posedge clk);
        pin <= 1'b0;
        repeat (4) @(posedge clk);
    end
    rd_chk(8'h23, 8'h03, "events");
    rd_chk(8'h27, 8'h02, "event high");
    wr_reg(8'h26, 8'h0C);
endtask
task t_t0;
    wr_reg(8'h3C, 8'h00);
    wr_reg(8'h25, 8'hFE);
    wr_reg(8'h24, 8'h35);
    rd_chk(8'h24, 8'h35, "t0 mode");
    wr_reg(8'h3F, 8'h04);
    rd_chk(8'h3F, 8'h04, "enable");
    wr_reg(8'h23, 8'hC0);
    wait_irq(1, 200);
    rd_chk(8'h3C, 8'h04, "t0 flag");
    rd_chk(8'h25, 8'hFE, "t0 reload");
    wr_reg(8'h3F, 8'h00);
    wr_reg(8'h3C, 8'h00);
    wr_reg(8'h24, 8'h25);
    wr_reg(8'h25, 8'hFF);
    wr_reg(8'h3F, 8'h04);
    wait_irq(1, 200);
    rd_chk(8'h25, 8'h00, "t0 wrap");
    wr_reg(8'h3F, 8'h00);
    idle(1);
    sys_run <= 1'b0;
    wr_reg(8'h25, 8'h40);
    idle(80);
    rd_chk(8'h25, 8'h40, "t0 frozen");
    idle(1);
    sys_run <= 1'b1;
    wr_reg(8'h24, 8'h05);
    wr_reg(8'h25, 8'h50);
    idle(80);
    rd_chk(8'h25, 8'h50, "t0 held");
endtask
task t_t1;
    wr_reg(8'h3C, 8'h00);
    idle(1);
    stby <= 1'b1;
    wr_reg(8'h27, 8'hFD);
    wr_reg(8'h26, 8'h17);
    idle(40);
    rd_chk(8'h27, 8'hFD, "t1 standby");
    idle(1);
    stby <= 1'b0;
    wr_reg(8'h3F, 8'h08);
    wait_irq(2, 100);
    rd_chk(8'h3C, 8'h08, "t1 flag");
    wr_reg(8'h3F, 8'h00);
    wr_reg(8'h26, 8'h0C);
endtask
task t_base;
    wr_reg(8'h23, 8'h00);
    wr_reg(8'h21, 8'h0B);
    rd_chk(8'h21, 8'h00, "select");
    wr_reg(8'h3C, 8'h00);
    wr_reg(8'h3F, 8'h20);
    idle(1);
    stby <= 1'b1;
    wait_irq(0, 10000);
    idle(1);
    stby <= 1'b0;
    wr_reg(8'h21, 8'h07);
    wr_reg(8'h23, 8'hC0);
    wr_reg(8'h3C, 8'h00);
    rd_chk(8'h3C, 8'h00, "flag clear");
    wait_irq(0, 600);
    wr_reg(8'h3F, 8'h00);
endtask
initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    pin = 1'b0;
    sys_run = 1'b1;
    stby = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_prs;
    t_ext;
    t_t0;
    t_t1;
    t_base;
    idle(4);
    wrap_up;
end
initial begin
    #(40 * 30000);
    num_errors++;
    wrap_up;
end
endmodule
